// File: rtl/line_range_zc_gating.sv
// line range state, polarity deglitch, open loop pulses and drive gating
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`include "zc_gating_defs.svh"

module line_range_zc_gating #(
   parameter int unsigned QUAL_CYC    = `QUAL_US * `CLK_MHZ,
   parameter int unsigned BLANK_CYC   = `BLANK_MS * 1000 * `CLK_MHZ,
   parameter int unsigned LOCK_CYC    = `LOCKOUT_MS * 1000 * `CLK_MHZ,
   parameter int unsigned FILT_CYC    = `POL_FILT_US * `CLK_MHZ,
   parameter int unsigned OL_UNIT_CYC = `OL_UNIT_US * `CLK_MHZ,
   parameter int unsigned SETTLE_CYC  = `SETTLE_US * `CLK_MHZ
) (
   // clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      nrst,
   // apb slave
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [7:0]                paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   // comparator and modulator inputs
   input  wire zc_gating_pkg::line_cmp_s  line_cmp,
   input  wire logic                      polarity_raw,
   input  wire logic                      primary_duty_drive,
   // outputs toward gate drivers and compensator
   output zc_gating_pkg::pin_drive_s      pin_drive,
   output zc_gating_pkg::drive_en_s       drive_en,
   output logic                           high_line,
   output logic                           polarity
);
   import zc_gating_pkg::*;

   localparam int unsigned CW = `CNT_W;

   if (LOCK_CYC >= (1 << CW) || BLANK_CYC >= (1 << CW) || QUAL_CYC >= (1 << CW) ||
       FILT_CYC >= (1 << CW) || SETTLE_CYC >= (1 << CW) || OL_UNIT_CYC == 0 ||
       (OL_UNIT_CYC * 16) >= (1 << CW) || QUAL_CYC == 0 || FILT_CYC == 0)
   begin : g_bad_params
      $error("timer parameter out of range for counter width");
   end

   function automatic logic [CW-1:0] on_len(input logic [1:0] idx);
      on_len = CW'((32'(idx) + 32'd1) * OL_UNIT_CYC);
   endfunction

   logic [31:0]   ctrl;
   logic          run;
   logic [CW-1:0] qual_cnt;
   logic [CW-1:0] blank_cnt;
   logic [CW-1:0] lock_cnt;
   logic [CW-1:0] filt_cnt;
   logic          pol_edge;
   logic          pol_rise;
   open_loop_e    ol_state;
   open_loop_e    next_ol_state;
   logic [CW-1:0] ol_cnt;
   logic [1:0]    ol_idx;
   logic          ol_to_low;
   logic          ol_busy;
   logic          comp_pulse;
   logic [31:0]   rd_word;
   logic          addr_ok;

   assign run        = ctrl[`CTRL_RUN_BIT];
   assign ol_busy    = (ol_state != OL_IDLE);
   assign comp_pulse = ~primary_duty_drive;

   // apb register access, zero wait state
   assign addr_ok = (paddr == `REG_CTRL) || (paddr == `REG_STATUS);

   always_comb
   begin
      rd_word = 32'h0;
      case (paddr)
         `REG_CTRL:   rd_word = ctrl;
         `REG_STATUS: rd_word = {20'h0, ol_idx, ol_state, lock_cnt != '0, drive_en, polarity, high_line};
         default:     rd_word = 32'h0;
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end
      else
      begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         prdata  <= (psel && !penable && !pwrite) ? rd_word : 32'h0;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         ctrl <= `CTRL_RESET;
      else if (psel && penable && pready && pwrite && paddr == `REG_CTRL)
         ctrl <= pwdata;
   end

   // line range state machine
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         high_line <= 1'b0;
         qual_cnt  <= '0;
         blank_cnt <= '0;
         lock_cnt  <= '0;
      end
      else if (!high_line)
      begin
         blank_cnt <= '0;
         if (lock_cnt != '0)
            lock_cnt <= lock_cnt - 1'b1;
         if (!line_cmp.above_high_entry || lock_cnt != '0)
            qual_cnt <= '0;
         else if (qual_cnt == CW'(QUAL_CYC))
         begin
            high_line <= 1'b1;
            qual_cnt  <= '0;
         end
         else
            qual_cnt <= qual_cnt + 1'b1;
      end
      else
      begin
         qual_cnt <= '0;
         if (!line_cmp.below_low_entry)
            blank_cnt <= '0;
         else if (blank_cnt == CW'(BLANK_CYC))
         begin
            high_line <= 1'b0;
            blank_cnt <= '0;
            lock_cnt  <= CW'(LOCK_CYC);
         end
         else
            blank_cnt <= blank_cnt + 1'b1;
      end
   end
   // high_line drives the compensator gain divide by four

   // polarity deglitch filter
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         polarity <= 1'b0;
         filt_cnt <= '0;
         pol_edge <= 1'b0;
         pol_rise <= 1'b0;
      end
      else
      begin
         pol_edge <= 1'b0;
         if (polarity_raw == polarity)
            filt_cnt <= '0;
         else if (filt_cnt == CW'(FILT_CYC))
         begin
            polarity <= polarity_raw;
            filt_cnt <= '0;
            pol_edge <= 1'b1;
            pol_rise <= polarity_raw;
         end
         else
            filt_cnt <= filt_cnt + 1'b1;
      end
   end

   // open loop pulse sequencer
   always_comb
   begin
      next_ol_state = ol_state;
      case (ol_state)
         OL_IDLE:
            if (pol_edge && run)
               next_ol_state = OL_ON;
         OL_ON:
            if (ol_cnt == on_len(ol_idx) - 1'b1)
               next_ol_state = OL_OFF;
         OL_OFF:
            if (ol_cnt == CW'(32'(on_len(ol_idx)) * `OL_OFF_RATIO) - 1'b1)
               next_ol_state = (ol_idx == `OL_LAST_IDX) ? OL_SETTLE : OL_ON;
         OL_SETTLE:
            if (ol_cnt >= CW'(SETTLE_CYC))
               next_ol_state = OL_IDLE;
         default:
            next_ol_state = OL_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ol_state  <= OL_IDLE;
         ol_cnt    <= '0;
         ol_idx    <= 2'h0;
         ol_to_low <= 1'b0;
      end
      else
      begin
         ol_state <= next_ol_state;
         if (ol_state == OL_IDLE)
         begin
            ol_cnt    <= '0;
            ol_idx    <= 2'h0;
            ol_to_low <= pol_rise;
         end
         else if (next_ol_state != ol_state)
         begin
            ol_cnt <= '0;
            if (ol_state == OL_OFF)
               ol_idx <= ol_idx + 2'h1;
         end
         else
            ol_cnt <= ol_cnt + 1'b1;
      end
   end

   // enables with start and stop hysteresis
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         drive_en <= '0;
      else if (!run || ol_busy || pol_edge)
         drive_en <= '0;
      else
      begin
         if (line_cmp.above_primary_start)
            drive_en.primary <= 1'b1;
         else if (line_cmp.below_primary_stop)
            drive_en.primary <= 1'b0;
         if (line_cmp.above_slow_start)
            drive_en.slow_leg <= 1'b1;
         else if (line_cmp.below_slow_stop || line_cmp.below_primary_stop)
            drive_en.slow_leg <= 1'b0;
         if (line_cmp.above_complement_start)
            drive_en.complement <= 1'b1;
         else if (line_cmp.below_complement_stop || line_cmp.below_primary_stop)
            drive_en.complement <= 1'b0;
      end
   end

   // routing of the three classes onto the pins
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         pin_drive <= '0;
      else if (ol_state == OL_ON)
      begin
         pin_drive.fast_leg_low_drive  <= ol_to_low;
         pin_drive.fast_leg_high_drive <= !ol_to_low;
         pin_drive.slow_leg_low_drive  <= 1'b0;
         pin_drive.slow_leg_high_drive <= 1'b0;
      end
      else if (ol_busy)
         pin_drive <= '0;
      else if (polarity)
      begin
         pin_drive.fast_leg_low_drive  <= drive_en.primary && primary_duty_drive;
         pin_drive.fast_leg_high_drive <= drive_en.complement && comp_pulse;
         pin_drive.slow_leg_low_drive  <= drive_en.slow_leg;
         pin_drive.slow_leg_high_drive <= 1'b0;
      end
      else
      begin
         pin_drive.fast_leg_high_drive <= drive_en.primary && primary_duty_drive;
         pin_drive.fast_leg_low_drive  <= drive_en.complement && comp_pulse;
         pin_drive.slow_leg_high_drive <= drive_en.slow_leg;
         pin_drive.slow_leg_low_drive  <= 1'b0;
      end
   end
   // comparator bits sampled directly, durations as cycle counts
   // all outputs registered on sys_clk

endmodule

// File: rtl/zc_gating_defs.svh
// constants for line range detection and zero crossing drive gating
`ifndef ZC_GATING_DEFS_SVH
`define ZC_GATING_DEFS_SVH

`define CLK_MHZ          125
`define QUAL_US          300
`define BLANK_MS         25
`define LOCKOUT_MS       500
`define POL_FILT_US      50
`define OL_UNIT_US       1
`define OL_OFF_RATIO     4
`define OL_LAST_IDX      2'h3
`define SETTLE_US        2
`define CNT_W            26

`define REG_CTRL         8'h00
`define REG_STATUS       8'h04
`define CTRL_RUN_BIT     0
`define CTRL_RESET       32'h0000_0000

`endif

// File: rtl/zc_gating_pkg.sv
// types for line range detection and zero crossing drive gating
package zc_gating_pkg;

   // comparator results, all synchronous to sys_clk
   typedef struct packed {
      logic above_high_entry;
      logic below_low_entry;
      logic above_primary_start;
      logic below_primary_stop;
      logic above_slow_start;
      logic below_slow_stop;
      logic above_complement_start;
      logic below_complement_stop;
   } line_cmp_s;

   // the four pin drives
   typedef struct packed {
      logic fast_leg_high_drive;
      logic fast_leg_low_drive;
      logic slow_leg_high_drive;
      logic slow_leg_low_drive;
   } pin_drive_s;

   // per class drive enables
   typedef struct packed {
      logic primary;
      logic complement;
      logic slow_leg;
   } drive_en_s;

   typedef enum logic [3:0] {
      OL_IDLE   = 4'b0001,
      OL_ON     = 4'b0010,
      OL_OFF    = 4'b0100,
      OL_SETTLE = 4'b1000
   } open_loop_e;

endpackage

// File: tb/gate_driver_model.sv
// gate driver partner that counts shorted legs
module gate_driver_model (
   input wire logic                      sys_clk,
   input wire zc_gating_pkg::pin_drive_s pin_drive,
   output int                            shoot_count
);
   timeunit 1ns;
   timeprecision 1ps;
   import zc_gating_pkg::*;
   initial shoot_count = 0;
   // a leg shorts if both its switches conduct
   always @(posedge sys_clk)
      if ((pin_drive.fast_leg_high_drive && pin_drive.fast_leg_low_drive) ||
          (pin_drive.slow_leg_high_drive && pin_drive.slow_leg_low_drive)) shoot_count <= shoot_count + 1;
endmodule

// File: tb/line_range_zc_gating_bench.sv
// testbench for line range and zero crossing drive gating
module line_range_zc_gating_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import zc_gating_pkg::*;
   logic       sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, polarity_raw = 0, duty = 0, ol_hi = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic       pready, pslverr, high_line, polarity, err;
   line_cmp_s  line_cmp = 8'h00;
   pin_drive_s pin_drive;
   drive_en_s  drive_en;
   int         num_errors = 0, check_count = 0, shoot_count;
   wire logic  f = ol_hi ? pin_drive.fast_leg_high_drive : pin_drive.fast_leg_low_drive;

   line_range_zc_gating #(.QUAL_CYC(10), .BLANK_CYC(20), .LOCK_CYC(30), .FILT_CYC(5), .OL_UNIT_CYC(2))
      i_line_range_zc_gating (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .line_cmp(line_cmp), .polarity_raw(polarity_raw), .primary_duty_drive(duty), .pin_drive(pin_drive),
      .drive_en(drive_en), .high_line(high_line), .polarity(polarity));
   gate_driver_model i_gate_driver_model (.sys_clk(sys_clk), .pin_drive(pin_drive), .shoot_count(shoot_count));

   initial forever #4 sys_clk = ~sys_clk;

   task wrap_up;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk iff pready === 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task drv(input logic [7:0] c, input logic d, input logic p, input int n);
      @(posedge sys_clk);
      line_cmp <= c;
      duty <= d;
      polarity_raw <= p;
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   task ol(input logic hi);
      int n;
      ol_hi = hi;
      for (int k = 0; k < 4; k++)
      begin
         for (n = 0; f !== 1'b1 && n < 400; n++) @(negedge sys_clk);
         if (k == 0) chk(32'(n < 20), 32'h1);
         else chk(32'(n), 32'(8 * k));
         chk(32'(hi ? pin_drive.fast_leg_low_drive : pin_drive.fast_leg_high_drive), 32'h0);
         for (n = 0; f === 1'b1 && n < 400; n++) @(negedge sys_clk);
         chk(32'(n), 32'(2 * k + 2));
      end
      // start level from the last off time through the settle window, no enable until idle
      @(posedge sys_clk);
      line_cmp <= 8'h20;
      repeat (250) @(negedge sys_clk);
      chk(32'(drive_en), 32'h0);
      repeat (50) @(negedge sys_clk);
      chk(32'(drive_en), 32'h4);
   endtask

   initial
   begin
      repeat (5000) @(posedge sys_clk);
      num_errors++;
      wrap_up;
   end

   initial
   begin
      repeat (8) @(posedge sys_clk);
      nrst <= 1'b1;
      @(negedge sys_clk);
      chk(32'({high_line, pin_drive, drive_en}), 32'h0);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h40);
      apb(1'b1, 8'h08, 32'h5);
      chk(32'(err), 32'h1);
      drv(8'h20, 0, 0, 3);
      chk(32'(drive_en), 32'h0);
      apb(1'b1, 8'h00, 32'h1);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h1);
      chk(32'(drive_en), 32'h4);
      $display("test registers done");
      drv(8'h80, 0, 0, 9);
      drv(8'h00, 0, 0, 1);
      chk(32'(high_line), 32'h0);
      drv(8'h80, 0, 0, 13);
      chk(32'(high_line), 32'h1);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd & 32'h1, 32'h1);
      drv(8'h40, 0, 0, 15);
      drv(8'h00, 0, 0, 1);
      chk(32'(high_line), 32'h1);
      drv(8'h40, 0, 0, 25);
      chk(32'(high_line), 32'h0);
      drv(8'h80, 0, 0, 20);
      chk(32'(high_line), 32'h0);
      drv(8'h80, 0, 0, 25);
      chk(32'(high_line), 32'h1);
      $display("test line range done");
      drv(8'h00, 0, 1, 4);
      drv(8'h00, 0, 0, 8);
      chk(32'(polarity), 32'h0);
      drv(8'h00, 0, 1, 0);
      ol(1'b0);
      chk(32'(polarity), 32'h1);
      drv(8'h00, 0, 0, 0);
      ol(1'b1);
      drv(8'h00, 0, 1, 0);
      ol(1'b0);
      drv(8'h00, 0, 1, 40);
      $display("test open loop done");
      drv(8'h20, 1, 1, 3);
      chk(32'(drive_en), 32'h4);
      chk(32'(pin_drive), 32'h4);
      drv(8'h28, 1, 1, 3);
      chk(32'(pin_drive), 32'h5);
      drv(8'h2a, 0, 1, 3);
      chk(32'(drive_en), 32'h7);
      chk(32'(pin_drive), 32'h9);
      drv(8'h00, 0, 1, 3);
      chk(32'(drive_en), 32'h7);
      drv(8'h05, 1, 1, 3);
      chk(32'(drive_en), 32'h4);
      drv(8'h15, 1, 1, 3);
      chk(32'({pin_drive, drive_en}), 32'h0);
      chk(32'(shoot_count), 32'h0);
      $display("test zero crossing done");
      wrap_up;
   end
endmodule

// File: tb/line_range_zc_gating_checker.sv
// concurrent checks on the range, polarity and drive gating ports
module line_range_zc_gating_checker #(
   parameter int unsigned QUAL_CYC = 10,
   parameter int unsigned FILT_CYC = 5
) (
   input wire logic                     sys_clk,
   input wire logic                     nrst,
   input wire zc_gating_pkg::line_cmp_s line_cmp,
   input wire logic                     polarity_raw,
   input wire logic                     primary_duty_drive,
   input wire zc_gating_pkg::pin_drive_s pin_drive,
   input wire zc_gating_pkg::drive_en_s drive_en,
   input wire logic                     high_line,
   input wire logic                     polarity
);
   timeunit 1ns;
   timeprecision 1ps;
   import zc_gating_pkg::*;
   int unsigned hi_cnt;
   int unsigned diff_cnt;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   // consecutive samples above high entry
   always_ff @(posedge sys_clk or negedge nrst)
      if (!nrst) hi_cnt <= 0;
      else if (!line_cmp.above_high_entry) hi_cnt <= 0;
      else if (hi_cnt < 1000) hi_cnt <= hi_cnt + 1;

   // consecutive samples of raw polarity against filtered
   always_ff @(posedge sys_clk or negedge nrst)
      if (!nrst) diff_cnt <= 0;
      else if (polarity_raw == polarity) diff_cnt <= 0;
      else if (diff_cnt < 1000) diff_cnt <= diff_cnt + 1;

   a_reset_low_range: assert property (!$past(nrst) |-> !high_line && pin_drive == 4'h0)
      else $error("outputs not idle after reset");
   a_qual_before_high: assert property ($rose(high_line) |-> hi_cnt >= QUAL_CYC + 1)
      else $error("high line entered too early");
   a_blank_then_low: assert property ($fell(high_line) |-> $past(line_cmp.below_low_entry))
      else $error("low line entered without low level");
   a_lockout_hold: assert property ($fell(high_line) |=> !high_line [*8])
      else $error("high line re-entered during lockout");
   a_deglitch_hold: assert property ($changed(polarity) |-> diff_cnt >= FILT_CYC + 1)
      else $error("polarity changed before filter time");
   a_quiet_after_edge: assert property ($changed(polarity) |-> ##2 (drive_en == 3'h0
      && !pin_drive.slow_leg_high_drive && !pin_drive.slow_leg_low_drive) [*8])
      else $error("drives active during open loop");
   a_no_shoot_through: assert property (!(pin_drive.fast_leg_high_drive && pin_drive.fast_leg_low_drive))
      else $error("both fast drives high");
   a_primary_stop: assert property (line_cmp.below_primary_stop && !line_cmp.above_primary_start
      |=> !drive_en.primary)
      else $error("primary not blanked below stop");
   a_slow_needs_start: assert property ($rose(drive_en.slow_leg) |-> $past(line_cmp.above_slow_start))
      else $error("slow leg enabled without start level");
   a_route_low: assert property (polarity && drive_en.primary
      |=> pin_drive.fast_leg_low_drive == $past(primary_duty_drive))
      else $error("primary pulse not on fast low drive");
   cover property ($rose(high_line));
   cover property ($changed(polarity));
   cover property ($rose(drive_en.slow_leg));
endmodule

bind line_range_zc_gating line_range_zc_gating_checker #(.QUAL_CYC(QUAL_CYC), .FILT_CYC(FILT_CYC))
   i_line_range_zc_gating_checker (.sys_clk(sys_clk), .nrst(nrst), .line_cmp(line_cmp),
   .polarity_raw(polarity_raw), .primary_duty_drive(primary_duty_drive), .pin_drive(pin_drive),
   .drive_en(drive_en), .high_line(high_line), .polarity(polarity));
